// >>> hdl/hpf_pkg.sv
// Shared constants of the handwheel pulse follower: register map,
// configuration word layout, limits and timing.
// Assumes a 200 MHz system clock and a 32-bit Avalon-MM register bus.
package hpf_pkg;

  // Word indexes of the registers; byte address is four times the index
  localparam logic [2:0] REG_CONFIG = 3'h0;
  localparam logic [2:0] REG_SPEED = 3'h1;
  localparam logic [2:0] REG_COMMAND = 3'h2;
  localparam logic [2:0] REG_STATUS = 3'h3;
  localparam logic [2:0] REG_POSITION = 3'h4;

  // Configuration word fields
  localparam int CFG_IN_MODE_LSB = 20;   // 2 bits: input mode
  localparam int CFG_IN_MULT_LSB = 16;   // 2 bits: input multiplication
  localparam int CFG_OUT_MULT_LSB = 8;   // 4 bits: output multiplication
  localparam int CFG_LIMIT_POL_BIT = 7;  // 1: limit active when energised
  localparam int CFG_OUT_MODE_BIT = 4;   // 1: cw/ccw, 0: pulse plus sign
  localparam logic [31:0] CONFIG_RESET = 32'h0020_0000;

  // Input modes
  localparam logic [1:0] IN_INDIVIDUAL = 2'h0;
  localparam logic [1:0] IN_DIR_PULSE = 2'h1;
  localparam logic [1:0] IN_TWO_PHASE = 2'h2;

  // Input multiplications
  localparam logic [1:0] MULT_X4 = 2'h0;
  localparam logic [1:0] MULT_X2 = 2'h1;
  localparam logic [1:0] MULT_X1 = 2'h2;

  // Output multiplication codes and their factors
  localparam logic [3:0] OMUL_CODE_1 = 4'h0;
  localparam logic [3:0] OMUL_CODE_2 = 4'h1;
  localparam logic [3:0] OMUL_CODE_5 = 4'h2;
  localparam logic [3:0] OMUL_CODE_10 = 4'h3;
  localparam logic [4:0] OMUL_1 = 5'h01;
  localparam logic [4:0] OMUL_2 = 5'h02;
  localparam logic [4:0] OMUL_5 = 5'h05;
  localparam logic [4:0] OMUL_10 = 5'h0a;

  // Command register bits
  localparam int CMD_ENABLE_BIT = 0;
  localparam int CMD_DECEL_BIT = 1;
  localparam int CMD_FORCED_BIT = 2;

  // Status register bits
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_DONE_BIT = 1;
  localparam int ST_ACTIVE_BIT = 2;
  localparam int ST_SET_ERR_BIT = 3;
  localparam int ST_LIMIT_ERR_BIT = 4;
  localparam int ST_DIR_BIT = 5;
  localparam int ST_PENDING_BIT = 6;

  // Speed range and clock rate
  localparam logic [22:0] SPEED_MIN = 23'h00_0001;
  localparam logic [22:0] SPEED_MAX = 23'h3d_0900;  // 4,000,000 pps
  localparam logic [22:0] SPEED_RESET = 23'h00_2710; // 10,000 pps
  localparam logic [28:0] CLOCK_HZ = 29'h0beb_c200;  // 200,000,000

endpackage : hpf_pkg

// >>> hdl/hpf_input_decoder.sv
// Decoder for the handwheel inputs: turns two synchronised phases into
// one-cycle count pulses with a direction, per mode and multiplication.
// Assumes its inputs are already synchronised to clock.
module hpf_input_decoder (
  input wire logic clock,
  input wire logic resetn,
  input wire logic phaseA,
  input wire logic phaseB,
  input wire logic [1:0] inMode,
  input wire logic [1:0] inMult,
  output logic countPulse,
  output logic countUp
);

  logic aPrev_q, bPrev_q, aPrev_d, bPrev_d;
  logic countPulse_d, countUp_d;
  logic aEdge, bEdge, aRise, bRise;

  // Edge detection and counting decisions
  always_comb begin
    aEdge = phaseA ^ aPrev_q;
    bEdge = phaseB ^ bPrev_q;
    aRise = phaseA & ~aPrev_q;
    bRise = phaseB & ~bPrev_q;
    aPrev_d = phaseA;
    bPrev_d = phaseB;
    countPulse_d = 1'b0;
    countUp_d = countUp;
    case (inMode)
      hpf_pkg::IN_TWO_PHASE: begin
        // Direction from which phase leads
        if (inMult == hpf_pkg::MULT_X4) begin
          countPulse_d = aEdge | bEdge;
          countUp_d = aEdge ? (phaseA ^ bPrev_q) : ~(phaseB ^ aPrev_q);
        end else if (inMult == hpf_pkg::MULT_X2) begin
          countPulse_d = aEdge;
          countUp_d = phaseA ^ phaseB;
        end else begin
          // x1 misses reversals inside one cycle of phases
          countPulse_d = aRise;
          countUp_d = ~phaseB;
        end
      end
      hpf_pkg::IN_DIR_PULSE: begin
        countPulse_d = aRise;
        countUp_d = ~phaseB;
      end
      default: begin
        // Individual inputs: A counts up, B counts down
        countPulse_d = aRise ^ bRise;
        countUp_d = aRise;
      end
    endcase
  end

  // Registers
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      aPrev_q <= 1'b0;
      bPrev_q <= 1'b0;
      countPulse <= 1'b0;
      countUp <= 1'b1;
    end else begin
      aPrev_q <= aPrev_d;
      bPrev_q <= bPrev_d;
      countPulse <= countPulse_d;
      countUp <= countUp_d;
    end
  end

endmodule // hpf_input_decoder

// >>> hdl/hpf_follower.sv
// Handwheel pulse follower axis: Avalon-MM registers, input decoding,
// scaled and speed-limited motor pulse output, limit and stop handling.
// Assumes asynchronous pins on the pulser and limit inputs and that the
// sibling positioning engines report busy and done events on this clock.
//
// The register offsets and the Avalon-MM interface to the registers were chosen for this implementation.
module hpf_follower (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [2:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWritedata,
  input wire logic [3:0] avsByteenable,
  output logic [31:0] avsReaddata,
  output logic avsWaitrequest,
  input wire logic pulserA,
  input wire logic pulserB,
  input wire logic limitPlus,
  input wire logic limitMinus,
  input wire logic positioningBusy,
  input wire logic positioningDone,
  output logic pulseOut,
  output logic signOut,
  output logic cwOut,
  output logic ccwOut
);

  typedef enum logic [2:0] {
    IDLE = 3'b001,
    FOLLOW = 3'b010,
    HALT = 3'b100
  } hpf_state_type;

  // Two-stage synchronisers for the four pins
  logic [3:0] pinMeta_q, pinSync_q;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pinMeta_q <= 4'h0;
      pinSync_q <= 4'h0;
    end else begin
      pinMeta_q <= {limitMinus, limitPlus, pulserB, pulserA};
      pinSync_q <= pinMeta_q;
    end
  end

  logic [31:0] config_q, config_d;
  logic [22:0] speed_q, speed_d;
  logic [2:0] command_q, command_d;
  logic done_q, done_d;
  logic setErr_q, setErr_d;
  logic limitErr_q, limitErr_d;
  logic waitReq_q, waitReq_d;
  logic [31:0] readData_q, readData_d;
  hpf_state_type state_q, state_d;
  logic [4:0] pending_q, pending_d;
  logic dir_q, dir_d;
  logic level_q, level_d;
  logic [28:0] acc_q, acc_d;
  logic signed [31:0] position_q, position_d;
  logic enablePrev_q;
  logic countPulse, countUp;

  hpf_input_decoder decoder (
    .clock(clock),
    .resetn(resetn),
    .phaseA(pinSync_q[0]),
    .phaseB(pinSync_q[1]),
    .inMode(config_q[hpf_pkg::CFG_IN_MODE_LSB +: 2]),
    .inMult(config_q[hpf_pkg::CFG_IN_MULT_LSB +: 2]),
    .countPulse(countPulse),
    .countUp(countUp)
  );

  // Configuration decode
  logic polEnergised, cwMode, plusActive, minusActive;
  logic [4:0] outMult;
  logic codeOk, speedOk, paramOk;
  always_comb begin
    polEnergised = config_q[hpf_pkg::CFG_LIMIT_POL_BIT];
    cwMode = config_q[hpf_pkg::CFG_OUT_MODE_BIT];
    // Unpowered limit reads active unless polarity is flipped
    plusActive = polEnergised ? pinSync_q[2] : ~pinSync_q[2];
    minusActive = polEnergised ? pinSync_q[3] : ~pinSync_q[3];
    codeOk = config_q[hpf_pkg::CFG_IN_MODE_LSB +: 2] != 2'h3;
    codeOk = codeOk && (config_q[hpf_pkg::CFG_IN_MULT_LSB +: 2] != 2'h3);
    case (config_q[hpf_pkg::CFG_OUT_MULT_LSB +: 4])
      hpf_pkg::OMUL_CODE_1: outMult = hpf_pkg::OMUL_1;
      hpf_pkg::OMUL_CODE_2: outMult = hpf_pkg::OMUL_2;
      hpf_pkg::OMUL_CODE_5: outMult = hpf_pkg::OMUL_5;
      hpf_pkg::OMUL_CODE_10: outMult = hpf_pkg::OMUL_10;
      default: begin
        outMult = hpf_pkg::OMUL_1;
        codeOk = 1'b0;
      end
    endcase
    speedOk = (speed_q >= hpf_pkg::SPEED_MIN) &&
              (speed_q <= hpf_pkg::SPEED_MAX);
    paramOk = codeOk && speedOk;
  end

  // Register bus: one wait cycle, then the answer with waitrequest low
  logic wrHit;
  logic [31:0] statusWord, byteMask;
  always_comb begin
    wrHit = avsWrite && !waitReq_q;
    waitReq_d = !((avsRead || avsWrite) && waitReq_q);
    byteMask = {{8{avsByteenable[3]}}, {8{avsByteenable[2]}},
                {8{avsByteenable[1]}}, {8{avsByteenable[0]}}};
    statusWord = 32'h0000_0000;
    statusWord[hpf_pkg::ST_BUSY_BIT] = positioningBusy;
    statusWord[hpf_pkg::ST_DONE_BIT] = done_q;
    statusWord[hpf_pkg::ST_ACTIVE_BIT] = state_q == FOLLOW;
    statusWord[hpf_pkg::ST_SET_ERR_BIT] = setErr_q;
    statusWord[hpf_pkg::ST_LIMIT_ERR_BIT] = limitErr_q;
    statusWord[hpf_pkg::ST_DIR_BIT] = dir_q;
    statusWord[hpf_pkg::ST_PENDING_BIT] = pending_q != 5'h00;
    readData_d = 32'h0000_0000;
    if (avsRead && waitReq_q) begin
      case (avsAddress)
        hpf_pkg::REG_CONFIG: readData_d = config_q;
        hpf_pkg::REG_SPEED: readData_d = {9'h000, speed_q};
        hpf_pkg::REG_COMMAND: readData_d = {29'h0, command_q};
        hpf_pkg::REG_STATUS: readData_d = statusWord;
        hpf_pkg::REG_POSITION: readData_d = position_q;
        default: readData_d = 32'h0000_0000;
      endcase
    end
    config_d = config_q;
    speed_d = speed_q;
    command_d = command_q;
    if (wrHit) begin
      case (avsAddress)
        hpf_pkg::REG_CONFIG:
          config_d = (config_q & ~byteMask) | (avsWritedata & byteMask);
        hpf_pkg::REG_SPEED:
          speed_d = (speed_q & ~byteMask[22:0]) |
                    (avsWritedata[22:0] & byteMask[22:0]);
        hpf_pkg::REG_COMMAND:
          if (avsByteenable[0]) begin
            command_d = avsWritedata[2:0];
          end
        default: config_d = config_q;
      endcase
    end
  end

  // Follower sequencing, burst generation and flags
  logic enable, enRise, decelReq, forcedReq;
  logic [28:0] accSum;
  logic step, limitAhead, startBlocked, clrSet, clrLimit;
  always_comb begin
    enable = command_q[hpf_pkg::CMD_ENABLE_BIT];
    decelReq = command_q[hpf_pkg::CMD_DECEL_BIT];
    forcedReq = command_q[hpf_pkg::CMD_FORCED_BIT];
    enRise = enable && !enablePrev_q;
    clrSet = wrHit && (avsAddress == hpf_pkg::REG_STATUS) &&
             avsByteenable[0] && avsWritedata[hpf_pkg::ST_SET_ERR_BIT];
    clrLimit = wrHit && (avsAddress == hpf_pkg::REG_STATUS) &&
               avsByteenable[0] && avsWritedata[hpf_pkg::ST_LIMIT_ERR_BIT];
    state_d = state_q;
    pending_d = pending_q;
    dir_d = dir_q;
    level_d = level_q;
    position_d = position_q;
    // Software clear first so a hardware set in this cycle wins
    done_d = positioningDone ? 1'b1 : done_q;
    setErr_d = clrSet ? 1'b0 : setErr_q;
    limitErr_d = clrLimit ? 1'b0 : limitErr_q;
    // Twice the pulse rate: one step per output edge
    accSum = acc_q + {5'h00, speed_q, 1'b0};
    step = 1'b0;
    acc_d = 29'h0000_0000;
    if (state_q == FOLLOW && (pending_q != 5'h00 || level_q)) begin
      step = accSum >= hpf_pkg::CLOCK_HZ;
      acc_d = step ? accSum - hpf_pkg::CLOCK_HZ : accSum;
    end
    // Only the limit ahead of travel matters, except that the plus limit also blocks a reverse start in cw/ccw mode
    limitAhead = dir_q ? plusActive : minusActive;
    startBlocked = countUp ? plusActive :
                   (minusActive || (cwMode && plusActive));
    case (state_q)
      IDLE: begin
        if (enRise && !positioningBusy) begin
          if (!paramOk) begin
            setErr_d = 1'b1;
            state_d = HALT;
          end else begin
            // A done event from a sibling in this cycle still wins
            done_d = positioningDone;
            state_d = FOLLOW;
          end
        end else if (enRise) begin
          state_d = HALT;
        end
      end
      FOLLOW: begin
        if (forcedReq) begin
          state_d = HALT;
          pending_d = 5'h00;
          level_d = 1'b0;
        end else if (decelReq) begin
          state_d = HALT;
          pending_d = 5'h00;
          level_d = 1'b0;
        end else if (!enable) begin
          state_d = IDLE;
          done_d = 1'b1;
          pending_d = 5'h00;
          level_d = 1'b0;
        end else if (countPulse && pending_q == 5'h00 && !level_q &&
                     startBlocked) begin
          limitErr_d = 1'b1;
          state_d = HALT;
        end else if (step && !level_q && limitAhead) begin
          limitErr_d = 1'b1;
          state_d = HALT;
          pending_d = 5'h00;
        end else begin
          if (step) begin
            level_d = !level_q;
            if (!level_q) begin
              position_d = dir_q ? position_q + 32'sd1
                                 : position_q - 32'sd1;
            end else begin
              pending_d = pending_q - 5'h01;
            end
          end
          // A new count reloads the burst unless level_d is high, when it is dropped; unfinished pulses are lost
          if (countPulse && !level_d) begin
            pending_d = outMult;
            dir_d = countUp;
          end
        end
      end
      HALT: begin
        // Restart needs enable dropped first
        if (!enable) begin
          state_d = IDLE;
          done_d = 1'b1;
        end
      end
      default: state_d = IDLE;
    endcase
  end

  // Registers of the bus, configuration and follower
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      config_q <= hpf_pkg::CONFIG_RESET;
      speed_q <= hpf_pkg::SPEED_RESET;
      command_q <= 3'h0;
      waitReq_q <= 1'b1;
      readData_q <= 32'h0000_0000;
      state_q <= IDLE;
      pending_q <= 5'h00;
      dir_q <= 1'b1;
      level_q <= 1'b0;
      acc_q <= 29'h0000_0000;
      position_q <= 32'sd0;
      done_q <= 1'b0;
      setErr_q <= 1'b0;
      limitErr_q <= 1'b0;
      enablePrev_q <= 1'b0;
    end else begin
      config_q <= config_d;
      speed_q <= speed_d;
      command_q <= command_d;
      waitReq_q <= waitReq_d;
      readData_q <= readData_d;
      state_q <= state_d;
      pending_q <= pending_d;
      dir_q <= dir_d;
      level_q <= level_d;
      acc_q <= acc_d;
      position_q <= position_d;
      done_q <= done_d;
      setErr_q <= setErr_d;
      limitErr_q <= limitErr_d;
      enablePrev_q <= enable;
    end
  end

  // Output pins, all registered
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pulseOut <= 1'b0;
      signOut <= 1'b0;
      cwOut <= 1'b0;
      ccwOut <= 1'b0;
    end else begin
      pulseOut <= level_d & ~cwMode;
      signOut <= ~dir_d & ~cwMode;
      cwOut <= level_d & cwMode & dir_d;
      ccwOut <= level_d & cwMode & ~dir_d;
    end
  end

  assign avsWaitrequest = waitReq_q;
  assign avsReaddata = readData_q;

endmodule // hpf_follower

// >>> bench/hpf_follower_props.sv
// Checker for the follower axis: bus timing, stop and limit behaviour.
// Assumes full-word writes; CONFIG and COMMAND are shadowed from them.
module hpf_follower_props (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [2:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWritedata,
  input wire logic [3:0] avsByteenable,
  input wire logic [31:0] avsReaddata,
  input wire logic avsWaitrequest,
  input wire logic pulserA,
  input wire logic pulserB,
  input wire logic limitPlus,
  input wire logic limitMinus,
  input wire logic positioningBusy,
  input wire logic positioningDone,
  input wire logic pulseOut,
  input wire logic signOut,
  input wire logic cwOut,
  input wire logic ccwOut
);
  logic [31:0] cfg_q, cfg_d;
  logic [2:0] cmd_q, cmd_d;
  logic [3:0] plusCnt_q, plusCnt_d, minusCnt_q, minusCnt_d;
  logic wrDone, plusAct, minusAct, quiet, stopReq;
  default clocking dc @(posedge clock); endclocking
  default disable iff (!resetn);
  // Shadows follow accepted writes; limit age counters saturate at 15
  always_comb begin
    wrDone = avsWrite && !avsWaitrequest;
    cfg_d = cfg_q;
    cmd_d = cmd_q;
    if (wrDone && avsAddress == hpf_pkg::REG_CONFIG) cfg_d = avsWritedata;
    if (wrDone && avsAddress == hpf_pkg::REG_COMMAND) begin
      cmd_d = avsWritedata[2:0];
    end
    plusAct = cfg_q[hpf_pkg::CFG_LIMIT_POL_BIT] ? limitPlus : !limitPlus;
    minusAct = cfg_q[hpf_pkg::CFG_LIMIT_POL_BIT] ? limitMinus : !limitMinus;
    plusCnt_d = !plusAct ? 4'h0 : plusCnt_q + {3'h0, plusCnt_q != 4'hf};
    minusCnt_d = !minusAct ? 4'h0 : minusCnt_q + {3'h0, minusCnt_q != 4'hf};
    quiet = !cmd_q[hpf_pkg::CMD_ENABLE_BIT];
    stopReq = cmd_q[hpf_pkg::CMD_DECEL_BIT] | cmd_q[hpf_pkg::CMD_FORCED_BIT];
  end
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cfg_q <= hpf_pkg::CONFIG_RESET;
      cmd_q <= 3'h0;
      plusCnt_q <= 4'h0;
      minusCnt_q <= 4'h0;
    end else begin
      cfg_q <= cfg_d;
      cmd_q <= cmd_d;
      plusCnt_q <= plusCnt_d;
      minusCnt_q <= minusCnt_d;
    end
  end
  // Six settled cycles cover the pin synchronisers and output register
  a_wait_answer: assert property ((avsRead || avsWrite) && avsWaitrequest
    |=> !avsWaitrequest) else $error("bus answer not after one wait");
  a_wait_single: assert property (!avsWaitrequest |=> avsWaitrequest)
    else $error("waitrequest low for more than one cycle");
  a_unmapped_zero: assert property (avsRead && !avsWaitrequest &&
    avsAddress > 3'h4 |-> avsReaddata == 32'h0)
    else $error("unmapped read not zero");
  a_busy_shown: assert property (
    avsRead && !avsWaitrequest && avsAddress == hpf_pkg::REG_STATUS &&
    $stable(positioningBusy) && $past(positioningBusy, 2) == positioningBusy
    |-> avsReaddata[hpf_pkg::ST_BUSY_BIT] == positioningBusy)
    else $error("busy flag not passed through");
  a_idle_quiet: assert property (
    quiet && $past(quiet) && $past(quiet, 2) && $past(quiet, 3)
    |-> !$rose(pulseOut) && !$rose(cwOut) && !$rose(ccwOut))
    else $error("motor pulse without follower enable");
  a_stop_halts: assert property (
    stopReq && $past(stopReq) && $past(stopReq, 2) && $past(stopReq, 3)
    |-> !$rose(pulseOut) && !$rose(cwOut) && !$rose(ccwOut))
    else $error("motor pulse during stop request");
  a_plus_limit: assert property (plusCnt_q > 4'h5 |->
    !($rose(pulseOut) && !signOut) && !$rose(cwOut))
    else $error("forward pulse into active plus limit");
  a_minus_limit: assert property (minusCnt_q > 4'h5 |->
    !($rose(pulseOut) && signOut) && !$rose(ccwOut))
    else $error("reverse pulse into active minus limit");
  a_cw_exclusive: assert property (!(cwOut && ccwOut))
    else $error("both direction outputs high");
  c_reverse: cover property ($rose(pulseOut) && signOut);
  c_limit_held: cover property (plusCnt_q == 4'hf && !quiet);
  c_stopped: cover property (stopReq && !quiet);
endmodule // hpf_follower_props

bind hpf_follower hpf_follower_props hpf_follower_props_i (
  .clock(clock), .resetn(resetn), .avsAddress(avsAddress),
  .avsRead(avsRead), .avsWrite(avsWrite), .avsWritedata(avsWritedata),
  .avsByteenable(avsByteenable), .avsReaddata(avsReaddata),
  .avsWaitrequest(avsWaitrequest), .pulserA(pulserA), .pulserB(pulserB),
  .limitPlus(limitPlus), .limitMinus(limitMinus),
  .positioningBusy(positioningBusy), .positioningDone(positioningDone),
  .pulseOut(pulseOut), .signOut(signOut), .cwOut(cwOut), .ccwOut(ccwOut));

// >>> bench/hpf_pulser_model.sv
// Handwheel model: two quadrature phases, one edge per step.
// Assumes the bench calls turn from one process at a time.
module hpf_pulser_model (
  input wire logic clock,
  output logic phaseA,
  output logic phaseB
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] step = 2'h0;
  // Phase A leads B when turning forward; phases never jump two states
  assign phaseA = step[1] ^ step[0];
  assign phaseB = step[1];
  // Each edge is one count at x4; a 25 per turn wheel gives one per detent
  task automatic turn(input bit rev, input int edges, input int gap);
    for (int i = 0; i < edges; i++) begin
      @(posedge clock);
      step <= rev ? step - 2'h1 : step + 2'h1;
      repeat (gap) @(posedge clock);
    end
  endtask
endmodule // hpf_pulser_model

// >>> bench/hpf_follower_tb_top.sv
// Bench for the follower axis: Avalon tasks, handwheel and limit stimulus.
// Assumes the checker attaches itself by bind.
module hpf_follower_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] ALL = 32'hffff_ffff;
  localparam logic [31:0] M_BUSY = 32'h1 << hpf_pkg::ST_BUSY_BIT;
  localparam logic [31:0] M_DONE = 32'h1 << hpf_pkg::ST_DONE_BIT;
  localparam logic [31:0] M_ACT = 32'h1 << hpf_pkg::ST_ACTIVE_BIT;
  localparam logic [31:0] M_SET = 32'h1 << hpf_pkg::ST_SET_ERR_BIT;
  localparam logic [31:0] M_LIM = 32'h1 << hpf_pkg::ST_LIMIT_ERR_BIT;
  localparam logic [31:0] M_DIR = 32'h1 << hpf_pkg::ST_DIR_BIT;
  localparam logic [31:0] SPD = {9'h0, hpf_pkg::SPEED_MAX};
  localparam logic [31:0] E_CFG [4] = '{32'h0020_0080, 32'h0020_0080,
    32'h0030_0080, 32'h0020_0080};
  localparam logic [31:0] E_SPD [4] = '{32'h0, 32'h003d_0901, SPD, 32'h1};
  localparam logic [31:0] E_EXP [4] = '{M_SET, M_SET, M_SET, M_ACT};
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic [2:0] avsAddress = 3'h0;
  logic avsRead = 1'b0;
  logic avsWrite = 1'b0;
  logic [31:0] avsWritedata = 32'h0;
  logic [3:0] avsByteenable = 4'hf;
  logic [31:0] avsReaddata, rd;
  logic avsWaitrequest, pulserA, pulserB, pulseOut, signOut, cwOut, ccwOut;
  logic limitPlus = 1'b0;
  logic limitMinus = 1'b0;
  logic positioningBusy = 1'b0;
  logic positioningDone = 1'b0;
  logic lastOut = 1'b0;
  int miscompares = 0;
  int cmp_count = 0;
  int pulses = 0;
  int cycles = 0;
  int pos = 0;
  int mark;
  hpf_follower hpf_follower_i (.clock(clock), .resetn(resetn),
    .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
    .avsWritedata(avsWritedata), .avsByteenable(avsByteenable),
    .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest),
    .pulserA(pulserA), .pulserB(pulserB), .limitPlus(limitPlus),
    .limitMinus(limitMinus), .positioningBusy(positioningBusy),
    .positioningDone(positioningDone), .pulseOut(pulseOut),
    .signOut(signOut), .cwOut(cwOut), .ccwOut(ccwOut));
  hpf_pulser_model hpf_pulser_model_i (.clock(clock), .phaseA(pulserA),
    .phaseB(pulserB));
  always #2.5 clock = ~clock;
  // Count motor pulse rises of either output style; cut a hang short
  always @(posedge clock) begin
    lastOut <= pulseOut | cwOut | ccwOut;
    if ((pulseOut | cwOut | ccwOut) && !lastOut) pulses <= pulses + 1;
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      miscompares++;
      complete_run();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
    input string what);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Request held until waitrequest is sampled low at a rising edge
  task automatic busWrite(input logic [2:0] a, input logic [31:0] d);
    @(posedge clock);
    avsAddress <= a;
    avsWritedata <= d;
    avsWrite <= 1'b1;
    do @(posedge clock); while (avsWaitrequest !== 1'b0);
    avsWrite <= 1'b0;
  endtask
  task automatic busRead(input logic [2:0] a, output logic [31:0] d);
    @(posedge clock);
    avsAddress <= a;
    avsRead <= 1'b1;
    do @(posedge clock); while (avsWaitrequest !== 1'b0);
    d = avsReaddata;
    avsRead <= 1'b0;
  endtask
  task automatic regChk(input logic [2:0] a, input logic [31:0] m,
    input logic [31:0] exp, input string what);
    busRead(a, rd);
    chk(rd & m, exp, what);
  endtask
  // Drop enable, load parameters, clear errors, then enable again
  task automatic start(input logic [31:0] cfg, input logic [31:0] spd);
    busWrite(hpf_pkg::REG_COMMAND, 32'h0);
    busWrite(hpf_pkg::REG_CONFIG, cfg);
    busWrite(hpf_pkg::REG_SPEED, spd);
    busWrite(hpf_pkg::REG_STATUS, M_SET | M_LIM);
    busWrite(hpf_pkg::REG_COMMAND, 32'h1);
    repeat (4) @(posedge clock);
  endtask
  // Gap of 400 cycles lets a burst of five at full speed finish first
  task automatic spin(input bit rev, input int edges, input int expP,
    input string what);
    mark = pulses;
    hpf_pulser_model_i.turn(rev, edges, 400);
    chk(pulses - mark, expP, what);
    pos = rev ? pos - expP : pos + expP;
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    regChk(hpf_pkg::REG_CONFIG, ALL, hpf_pkg::CONFIG_RESET, "config");
    regChk(hpf_pkg::REG_SPEED, ALL, {9'h0, hpf_pkg::SPEED_RESET}, "speed");
    regChk(hpf_pkg::REG_COMMAND, ALL, 32'h0, "command");
    regChk(hpf_pkg::REG_STATUS, 32'h1f, 32'h0, "status");
    busWrite(3'h5, ALL);
    busWrite(hpf_pkg::REG_POSITION, 32'h0000_0055);
    regChk(3'h5, ALL, 32'h0, "unmapped");
    regChk(hpf_pkg::REG_POSITION, ALL, 32'h0, "position read only");
    $display("test reset finished");
    start(hpf_pkg::CONFIG_RESET, SPD);
    spin(0, 1, 0, "unwired limits");
    regChk(hpf_pkg::REG_STATUS, M_LIM | M_ACT, M_LIM, "limit err");
    busWrite(hpf_pkg::REG_COMMAND, 32'h0);
    regChk(hpf_pkg::REG_STATUS, M_DONE, M_DONE, "done on drop");
    start(32'h0020_0080, SPD);
    regChk(hpf_pkg::REG_STATUS, M_DONE | M_ACT, M_ACT, "done clear");
    spin(0, 4, 4, "x1 forward");
    regChk(hpf_pkg::REG_POSITION, ALL, pos, "position up");
    regChk(hpf_pkg::REG_STATUS, M_DIR, M_DIR, "forward dir");
    start(32'h0020_0280, SPD);
    spin(0, 1, 5, "x5 forward");
    spin(1, 2, 10, "x5 reverse");
    regChk(hpf_pkg::REG_POSITION, ALL, pos, "position down");
    regChk(hpf_pkg::REG_STATUS, M_DIR, 32'h0, "reverse dir");
    $display("test multiples finished");
    limitMinus <= 1'b1;
    spin(0, 1, 5, "minus ignored");
    limitMinus <= 1'b0;
    limitPlus <= 1'b1;
    spin(1, 1, 5, "reverse at plus");
    spin(0, 1, 0, "forward at plus");
    regChk(hpf_pkg::REG_STATUS, M_LIM, M_LIM, "start refused");
    limitPlus <= 1'b0;
    start(32'h0020_0380, 32'h0006_1a80);
    mark = pulses;
    hpf_pulser_model_i.turn(0, 1, 1500);
    limitPlus <= 1'b1;
    repeat (6000) @(posedge clock);
    chk(pulses - mark > 0 && pulses - mark < 10, 32'h1, "cut");
    regChk(hpf_pkg::REG_STATUS, M_LIM, M_LIM, "run limit err");
    busRead(hpf_pkg::REG_POSITION, rd);
    pos = rd;
    limitPlus <= 1'b0;
    start(32'h0020_0290, SPD);
    spin(0, 1, 5, "cw forward");
    spin(1, 1, 5, "ccw reverse");
    limitPlus <= 1'b1;
    spin(1, 1, 0, "ccw at plus");
    regChk(hpf_pkg::REG_STATUS, M_LIM, M_LIM, "ccw limit err");
    limitPlus <= 1'b0;
    $display("test limits finished");
    positioningBusy <= 1'b1;
    start(32'h0020_0080, SPD);
    regChk(hpf_pkg::REG_STATUS, M_ACT | M_BUSY, M_BUSY, "busy");
    spin(0, 1, 0, "busy blocks");
    positioningBusy <= 1'b0;
    start(32'h0020_0080, SPD);
    positioningDone <= 1'b1;
    @(posedge clock);
    positioningDone <= 1'b0;
    repeat (3) @(posedge clock);
    regChk(hpf_pkg::REG_STATUS, M_DONE, M_DONE, "shared done");
    for (int b = 1; b < 3; b++) begin
      start(32'h0020_0080, SPD);
      busWrite(hpf_pkg::REG_COMMAND, 32'h1 | (32'h1 << b));
      spin(0, 1, 0, "stopped");
      regChk(hpf_pkg::REG_STATUS, M_ACT, 32'h0, "halted");
    end
    start(32'h0021_0080, SPD);
    spin(0, 4, 2, "x2 input");
    start(32'h0010_0080, SPD);
    spin(0, 4, 1, "dir pulse input");
    $display("test flags and stops finished");
    for (int i = 0; i < 4; i++) begin
      start(E_CFG[i], E_SPD[i]);
      regChk(hpf_pkg::REG_STATUS, M_SET | M_ACT, E_EXP[i], "set val");
    end
    $display("test set values finished");
    complete_run();
  end
endmodule // hpf_follower_tb_top
